// file: core/gpst_pkg.sv
// Constants and types of the graphics power-up self-test sequencer.
// Assumes a 20 MHz processor clock and byte-wide ROM and RAM ports.
package gpst_pkg;
	// ==========================================
	// Timing
	localparam int CLK_HZ = 20_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int VSYNC_GAP_MS = 25;
	localparam int VSYNC_GAP_CYC = VSYNC_GAP_MS * CYC_PER_MS;
	localparam int VECTOR_MAX_MS = 100;
	localparam int VECTOR_MAX_CYC = VECTOR_MAX_MS * CYC_PER_MS;
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CYC_PER_MS;
	localparam int LINK_WAIT_MS = 100;
	localparam int LINK_WAIT_CYC = LINK_WAIT_MS * CYC_PER_MS;
	localparam int SHOW_STEP_MS = 500;
	localparam int SHOW_STEP_CYC = SHOW_STEP_MS * CYC_PER_MS;
	// ==========================================
	// Memories
	localparam int ROM_SEG_BYTES = 4096;
	localparam int ROM_SEGS = 6;
	localparam int ROM_AW = 15;
	localparam int RAM_BYTES = 16384;
	localparam int RAM_AW = 14;
	localparam logic [7:0] RAM_PAT = 8'h55;
	localparam logic [7:0] ROM_SEED_ADD = 8'h01;
	localparam int REQ_TESTS = 4;
	// ==========================================
	// Fatal codes and their flash level pairs
	localparam logic [2:0] FATAL_CPU = 3'h1;
	localparam logic [2:0] FATAL_ROM = 3'h2;
	localparam logic [2:0] FATAL_RAM = 3'h3;
	localparam logic [2:0] FATAL_VSYNC = 3'h4;
	localparam logic [2:0] FATAL_VECTOR = 3'h5;
	localparam logic [1:0] FLASH_LO [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h0};
	localparam logic [1:0] FLASH_HI [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h3, 2'h0, 2'h0};
	// ==========================================
	// Types
	typedef struct packed {
		logic [1:0] g;
		logic [1:0] r;
		logic [1:0] b;
	} gpst_colour_t;
	localparam gpst_colour_t COLOUR_OF [8] = '{
		'{2'h0, 2'h0, 2'h0}, '{2'h0, 2'h2, 2'h1}, '{2'h1, 2'h0, 2'h2}, '{2'h1, 2'h2, 2'h3},
		'{2'h2, 2'h1, 2'h0}, '{2'h2, 2'h3, 2'h1}, '{2'h3, 2'h1, 2'h2}, '{2'h3, 2'h3, 2'h3}};
	typedef struct packed {
		logic valid;
		logic ok;
		logic local_mode;
	} gpst_link_rsp_t;
	typedef struct packed {
		logic done;
		logic pass;
	} gpst_eng_rsp_t;
	typedef enum logic [3:0] {
		T_CPU, T_ROM, T_RAM, T_BM_PART, T_VG, T_LINK,
		T_HOST, T_AUX, T_DISPLAY, T_BM_FULL, T_END
	} gpst_test_t;
	typedef enum logic [2:0] {
		MSG_NONE, MSG_OK, MSG_OFFLINE, MSG_BITMAP_ERROR_CODE, MSG_VECTOR_GENERATOR_ERROR_CODE,
		MSG_INTERNAL_LINK_ERROR_CODE, MSG_SERIAL_PORT_ERROR_CODE, MSG_HOST_LINK_ERROR_CODE
	} gpst_msg_t;
endpackage : gpst_pkg

// file: core/gpst_self_test.sv
// Self-test sequencer: power-up series, requested series, fatal flashing.
// Assumes ROM and RAM give read data in the same cycle as the read strobe.
//
// How it works
// - Power-up series starts by itself after every reset release.
// - CPU register test runs first; failure flashes fatal code one.
// - ROM is checked as 4K segments, two checksums per 8K.
// - Accumulator seeded with segment high address byte plus one, rotate-XOR, must end zero.
// - ROM failure flashes code two; colour shows failing segment number.
// - All 16K RAM bytes get checkerboard write and readback, both polarities.
// - RAM failure flashes code three; colour flashes failing bit number.
// - Vertical sync gap beyond 25 ms during power-up, after the CPU test, is fatal code four.
// - Vector lasting over 100 ms in bitmap or vector test is code five.
// - Partial bitmap test on first eight lines; failure shows bitmap message.
// - Vector generator pattern test; mismatch shows vector generator message.
// - Terminal status asked over the link; no valid reply shows link message.
// - Terminal in local mode gives offline message, not an error.
// - Requested tests start only from the confidence test sequence pulse.
// - Host loopback test; failure shows host link message.
// - Auxiliary port loopback test; failure shows serial port message.
// - Display test steps four levels of red, green, blue and white.
// - Full bitmap test; failure shows bitmap message.
// - Fatal codes flash mono between 0/1, 0/2, 0/3, 1/2, 1/3.
// - Any nonfatal message clears when the next host character arrives.
`timescale 1ns/1ps
module gpst_self_test #(
	parameter int VSYNC_GAP_CYC = gpst_pkg::VSYNC_GAP_CYC,
	parameter int VECTOR_MAX_CYC = gpst_pkg::VECTOR_MAX_CYC,
	parameter int FLASH_HALF_CYC = gpst_pkg::FLASH_HALF_CYC,
	parameter int LINK_WAIT_CYC = gpst_pkg::LINK_WAIT_CYC,
	parameter int SHOW_STEP_CYC = gpst_pkg::SHOW_STEP_CYC
) (
	input wire logic mclk, // Processor clock
	input wire logic rst_n, // Synchronous reset, terminal reset
	input wire logic host_char, // Pulse: character from host arrived
	input wire logic cts_start, // Pulse: confidence_test_sequence received
	input wire logic [3:0] cts_sel, // Requested test mask with that pulse
	output logic eng_req, // Pulse: start engine test
	output gpst_pkg::gpst_test_t eng_test, // Test the engine must run
	input wire gpst_pkg::gpst_eng_rsp_t eng_rsp, // Engine done and pass
	output logic rom_re, // ROM read strobe
	output logic [gpst_pkg::ROM_AW-1:0] rom_addr, // ROM byte address
	input wire logic [7:0] rom_data, // ROM data, in the strobe cycle
	output logic ram_re, // RAM read strobe
	output logic ram_we, // RAM write strobe
	output logic [gpst_pkg::RAM_AW-1:0] ram_addr, // RAM byte address
	output logic [7:0] ram_wdata, // RAM write data
	input wire logic [7:0] ram_rdata, // RAM data, in the strobe cycle
	input wire logic vsync, // Vertical sync level
	input wire logic vec_busy, // Vector generator drawing
	output logic link_req, // Pulse: terminal status request
	input wire gpst_pkg::gpst_link_rsp_t link_rsp, // Terminal status reply
	output logic [1:0] mono_level, // Monochrome intensity
	output gpst_pkg::gpst_colour_t colour, // Colour intensities
	output gpst_pkg::gpst_msg_t msg, // On-screen status message
	output logic busy, // A test series is running, or fatal error latched
	output logic fatal // Fatal error latched
);
	// ==========================================
	// Parameter checks
	if (VSYNC_GAP_CYC < 2 || VECTOR_MAX_CYC < 1 || FLASH_HALF_CYC < 1 ||
		LINK_WAIT_CYC < 1 || SHOW_STEP_CYC < 1) begin : g_bad
		$error("gpst_self_test: timing counts too small");
	end

	typedef enum logic [3:0] {
		ST_NEXT, ST_ENG_REQ, ST_ENG_WAIT, ST_ROM, ST_RAM, ST_LINK_REQ,
		ST_LINK_WAIT, ST_DISPLAY, ST_IDLE, ST_FATAL
	} gpst_state_t;

	// ==========================================
	// Helper functions
	// Lowest requested test at or after slot from
	function automatic gpst_pkg::gpst_test_t pick_req(input logic [3:0] sel, input int from);
		gpst_pkg::gpst_test_t t;
		t = gpst_pkg::T_END;
		for (int k = gpst_pkg::REQ_TESTS - 1; k >= 0; k--) begin
			if (k >= from && sel[k]) begin
				t = gpst_pkg::gpst_test_t'(4'(int'(gpst_pkg::T_HOST) + k));
			end
		end
		return t;
	endfunction : pick_req

	// Lowest failing bit of a compare
	function automatic logic [2:0] low_bit(input logic [7:0] v);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				n = 3'(i);
			end
		end
		return n;
	endfunction : low_bit

	// ==========================================
	// State
	gpst_state_t state;
	gpst_pkg::gpst_test_t cur;
	logic [3:0] sel;
	logic [14:0] idx;
	logic [2:0] seg;
	logic [7:0] acc;
	logic [1:0] ph;
	logic [7:0] exp_data;
	logic [31:0] tmr;
	logic [3:0] dstep;
	logic in_power_up;
	logic err_seen;
	logic offline_seen;
	logic [2:0] fatal_code;
	logic [2:0] fatal_num;
	logic vs_q;
	logic [31:0] vs_cnt;
	logic [31:0] vec_cnt;
	logic [31:0] flash_cnt;
	logic flash_ph;

	// ==========================================
	// Decode
	wire rom_end = idx == 15'(gpst_pkg::ROM_SEG_BYTES);
	wire ram_end = idx == 15'(gpst_pkg::RAM_BYTES);
	wire rom_issue = state == ST_ROM && !rom_end;
	wire ram_issue = state == ST_RAM && !ram_end;
	wire [7:0] pat = (idx[0] ^ ph[1]) ? ~gpst_pkg::RAM_PAT : gpst_pkg::RAM_PAT;
	wire rom_seg_done = state == ST_ROM && rom_end && !rom_re;
	wire rom_fail = rom_seg_done && acc != 8'h00;
	wire [7:0] ram_diff = ram_rdata ^ exp_data;
	wire ram_fail = state == ST_RAM && ram_re && ram_diff != 8'h00;
	wire ram_ph_done = state == ST_RAM && ram_end && !ram_re && !ram_we;
	wire eng_done = state == ST_ENG_WAIT && eng_rsp.done;
	wire cpu_fail = eng_done && !eng_rsp.pass && cur == gpst_pkg::T_CPU;
	wire vs_rise = vsync && !vs_q;
	wire vs_armed = in_power_up && cur != gpst_pkg::T_CPU && state != ST_FATAL;
	wire vs_fail = vs_armed && !vs_rise && vs_cnt == 32'(VSYNC_GAP_CYC - 1);
	wire vec_armed = state == ST_ENG_WAIT && (cur == gpst_pkg::T_BM_PART ||
		cur == gpst_pkg::T_VG || cur == gpst_pkg::T_BM_FULL);
	wire vec_fail = vec_armed && vec_busy && vec_cnt == 32'(VECTOR_MAX_CYC);
	wire fatal_hit = state != ST_FATAL && (cpu_fail || rom_fail || ram_fail || vs_fail || vec_fail);
	wire [2:0] fatal_in = cpu_fail ? gpst_pkg::FATAL_CPU : rom_fail ? gpst_pkg::FATAL_ROM :
		ram_fail ? gpst_pkg::FATAL_RAM : vs_fail ? gpst_pkg::FATAL_VSYNC :
		gpst_pkg::FATAL_VECTOR;
	wire [2:0] num_in = rom_fail ? seg : low_bit(ram_diff);
	wire [7:0] seed_next = {1'b0, seg + 3'h1, 4'h0} + gpst_pkg::ROM_SEED_ADD;
	wire gpst_pkg::gpst_test_t test_after = (cur == gpst_pkg::T_LINK) ? gpst_pkg::T_END :
		(cur < gpst_pkg::T_LINK) ? gpst_pkg::gpst_test_t'(cur + 4'h1) :
		pick_req(sel, int'(cur) - int'(gpst_pkg::T_HOST) + 1);
	wire gpst_pkg::gpst_msg_t eng_msg = (cur == gpst_pkg::T_VG) ?
		gpst_pkg::MSG_VECTOR_GENERATOR_ERROR_CODE :
		(cur == gpst_pkg::T_HOST) ? gpst_pkg::MSG_HOST_LINK_ERROR_CODE :
		(cur == gpst_pkg::T_AUX) ? gpst_pkg::MSG_SERIAL_PORT_ERROR_CODE :
		gpst_pkg::MSG_BITMAP_ERROR_CODE;
	wire tmr_end_link = tmr == 32'(LINK_WAIT_CYC - 1);
	wire tmr_end_show = tmr == 32'(SHOW_STEP_CYC - 1);
	wire [1:0] lvl = dstep[1:0];
	wire gpst_pkg::gpst_colour_t disp_colour = '{
		g: (dstep[3:2] == 2'h1 || dstep[3:2] == 2'h3) ? lvl : 2'h0,
		r: (dstep[3:2] == 2'h0 || dstep[3:2] == 2'h3) ? lvl : 2'h0,
		b: (dstep[3:2] == 2'h2 || dstep[3:2] == 2'h3) ? lvl : 2'h0};
	wire gpst_pkg::gpst_colour_t fatal_colour = (fatal_code == gpst_pkg::FATAL_ROM ||
		(fatal_code == gpst_pkg::FATAL_RAM && flash_ph)) ?
		gpst_pkg::COLOUR_OF[fatal_num] : '0;

	// ==========================================
	// Sequencer
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state <= ST_NEXT;
			cur <= gpst_pkg::T_CPU;
			sel <= 4'h0;
			idx <= 15'h0000;
			seg <= 3'h0;
			acc <= 8'h00;
			ph <= 2'h0;
			tmr <= 32'h0000_0000;
			dstep <= 4'h0;
			in_power_up <= 1'b1;
			err_seen <= 1'b0;
			offline_seen <= 1'b0;
			fatal_code <= 3'h0;
			fatal_num <= 3'h0;
			msg <= gpst_pkg::MSG_NONE;
		end else begin
			if (host_char) begin
				msg <= gpst_pkg::MSG_NONE;
			end
			unique case (state)
				ST_NEXT: begin
					idx <= 15'h0000;
					seg <= 3'h0;
					acc <= gpst_pkg::ROM_SEED_ADD;
					ph <= 2'h0;
					tmr <= 32'h0000_0000;
					dstep <= 4'h0;
					unique case (cur)
						gpst_pkg::T_ROM: state <= ST_ROM;
						gpst_pkg::T_RAM: state <= ST_RAM;
						gpst_pkg::T_LINK: state <= ST_LINK_REQ;
						gpst_pkg::T_DISPLAY: state <= ST_DISPLAY;
						gpst_pkg::T_END: begin
							state <= ST_IDLE;
							in_power_up <= 1'b0;
							if (!err_seen) begin
								msg <= offline_seen ? gpst_pkg::MSG_OFFLINE : gpst_pkg::MSG_OK;
							end
						end
						default: state <= ST_ENG_REQ;
					endcase
				end
				ST_ENG_REQ: state <= ST_ENG_WAIT;
				ST_ENG_WAIT: begin
					if (eng_done) begin
						if (!eng_rsp.pass) begin
							msg <= eng_msg;
							err_seen <= 1'b1;
						end
						cur <= test_after;
						state <= ST_NEXT;
					end
				end
				ST_ROM: begin
					if (rom_issue) begin
						idx <= idx + 15'h0001;
					end
					if (rom_re) begin
						acc <= {acc[6:0], acc[7]} ^ rom_data;
					end
					if (rom_seg_done) begin
						idx <= 15'h0000;
						seg <= seg + 3'h1;
						acc <= seed_next;
						if (seg == 3'(gpst_pkg::ROM_SEGS - 1)) begin
							cur <= test_after;
							state <= ST_NEXT;
						end
					end
				end
				ST_RAM: begin
					if (ram_issue) begin
						idx <= idx + 15'h0001;
					end
					if (ram_ph_done) begin
						idx <= 15'h0000;
						ph <= ph + 2'h1;
						if (ph == 2'h3) begin
							cur <= test_after;
							state <= ST_NEXT;
						end
					end
				end
				ST_LINK_REQ: begin
					tmr <= 32'h0000_0000;
					state <= ST_LINK_WAIT;
				end
				ST_LINK_WAIT: begin
					tmr <= tmr + 32'h0000_0001;
					if (link_rsp.valid || tmr_end_link) begin
						if (link_rsp.valid && link_rsp.local_mode) begin
							offline_seen <= 1'b1;
						end else if (!link_rsp.valid || !link_rsp.ok) begin
							msg <= gpst_pkg::MSG_INTERNAL_LINK_ERROR_CODE;
							err_seen <= 1'b1;
						end
						cur <= test_after;
						state <= ST_NEXT;
					end
				end
				ST_DISPLAY: begin
					tmr <= tmr_end_show ? 32'h0000_0000 : tmr + 32'h0000_0001;
					if (tmr_end_show) begin
						dstep <= dstep + 4'h1;
						if (dstep == 4'hF) begin
							cur <= test_after;
							state <= ST_NEXT;
						end
					end
				end
				ST_IDLE: begin
					if (cts_start) begin
						sel <= cts_sel;
						cur <= pick_req(cts_sel, 0);
						err_seen <= 1'b0;
						offline_seen <= 1'b0;
						state <= ST_NEXT;
					end
				end
				ST_FATAL: state <= ST_FATAL;
			endcase
			if (fatal_hit) begin
				state <= ST_FATAL;
				fatal_code <= fatal_in;
				fatal_num <= num_in;
			end
		end
	end

	// Memory strobes, requests and expected RAM data
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rom_re <= 1'b0;
			rom_addr <= '0;
			ram_re <= 1'b0;
			ram_we <= 1'b0;
			ram_addr <= '0;
			ram_wdata <= 8'h00;
			exp_data <= 8'h00;
			eng_req <= 1'b0;
			eng_test <= gpst_pkg::T_CPU;
			link_req <= 1'b0;
			busy <= 1'b1;
			fatal <= 1'b0;
		end else begin
			rom_re <= rom_issue && !fatal_hit;
			rom_addr <= {seg, idx[11:0]};
			ram_re <= ram_issue && ph[0] && !fatal_hit;
			ram_we <= ram_issue && !ph[0] && !fatal_hit;
			ram_addr <= idx[gpst_pkg::RAM_AW-1:0];
			ram_wdata <= pat;
			exp_data <= pat;
			eng_req <= state == ST_ENG_REQ && !fatal_hit;
			eng_test <= cur;
			link_req <= state == ST_LINK_REQ && !fatal_hit;
			busy <= state != ST_IDLE;
			fatal <= state == ST_FATAL || fatal_hit;
		end
	end

	// Watchdogs for sync gap and vector length
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			vs_q <= 1'b0;
			vs_cnt <= 32'h0000_0000;
			vec_cnt <= 32'h0000_0000;
		end else begin
			vs_q <= vsync;
			vs_cnt <= (vs_armed && !vs_rise) ? vs_cnt + 32'h0000_0001 : 32'h0000_0000;
			vec_cnt <= (vec_armed && vec_busy) ? vec_cnt + 32'h0000_0001 : 32'h0000_0000;
		end
	end

	// Flash timing and video outputs
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			flash_cnt <= 32'h0000_0000;
			flash_ph <= 1'b0;
			mono_level <= 2'h0;
			colour <= '0;
		end else begin
			if (state != ST_FATAL || flash_cnt == 32'(FLASH_HALF_CYC - 1)) begin
				flash_cnt <= 32'h0000_0000;
			end else begin
				flash_cnt <= flash_cnt + 32'h0000_0001;
			end
			flash_ph <= (state == ST_FATAL) && (flash_ph ^ (flash_cnt == 32'(FLASH_HALF_CYC - 1)));
			if (state == ST_FATAL) begin
				mono_level <= flash_ph ? gpst_pkg::FLASH_HI[fatal_code] :
					gpst_pkg::FLASH_LO[fatal_code];
				colour <= fatal_colour;
			end else begin
				mono_level <= 2'h0;
				colour <= (state == ST_DISPLAY) ? disp_colour : '0;
			end
		end
	end

	// ==========================================
	// Checks
	a_power_up_start: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(rst_n) |-> ##2 eng_req && eng_test == gpst_pkg::T_CPU)
		else $error("power-up series did not start with CPU test");
	a_fatal_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
		state == ST_FATAL |=> state == ST_FATAL && !eng_req && !rom_re && !link_req)
		else $error("testing resumed after fatal error");
	a_mono_pair: assert property (@(posedge mclk) disable iff (!rst_n)
		state == ST_FATAL && $past(state == ST_FATAL) |-> mono_level ==
		($past(flash_ph) ? gpst_pkg::FLASH_HI[fatal_code] : gpst_pkg::FLASH_LO[fatal_code]))
		else $error("fatal flash levels wrong");
	a_rom_fail: assert property (@(posedge mclk) disable iff (!rst_n)
		rom_fail |=> state == ST_FATAL && fatal_code == gpst_pkg::FATAL_ROM ##1
		colour == gpst_pkg::COLOUR_OF[fatal_num])
		else $error("ROM checksum failure not shown");
	a_ram_fail: assert property (@(posedge mclk) disable iff (!rst_n)
		ram_fail && !rom_fail && !cpu_fail |=> state == ST_FATAL &&
		fatal_code == gpst_pkg::FATAL_RAM && fatal_num == $past(num_in))
		else $error("RAM failure not latched");
	a_vsync_gap: assert property (@(posedge mclk) disable iff (!rst_n)
		vs_armed && !vs_rise |=> vs_cnt == $past(vs_cnt) + 32'h0000_0001 || state == ST_FATAL)
		else $error("sync gap counter stalled");
	a_vector_limit: assert property (@(posedge mclk) disable iff (!rst_n)
		vec_fail |=> state == ST_FATAL)
		else $error("vector timeout not fatal");
	a_msg_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		host_char && state inside {ST_IDLE, ST_ROM, ST_RAM, ST_ENG_REQ} |=>
		msg == gpst_pkg::MSG_NONE)
		else $error("status message not cleared by host character");
	a_req_only_seq: assert property (@(posedge mclk) disable iff (!rst_n)
		state == ST_IDLE && !cts_start |=> state == ST_IDLE)
		else $error("requested tests started without sequence");
	a_link_request: assert property (@(posedge mclk) disable iff (!rst_n)
		state == ST_LINK_REQ && !fatal_hit |=> link_req ##1 !link_req)
		else $error("status request pulse wrong");
	c_rom_fatal: cover property (@(posedge mclk) disable iff (!rst_n) rom_fail);
	c_requested: cover property (@(posedge mclk) disable iff (!rst_n)
		state == ST_IDLE && cts_start ##[1:8] eng_req);
	c_offline: cover property (@(posedge mclk) disable iff (!rst_n)
		msg == gpst_pkg::MSG_OFFLINE);
endmodule : gpst_self_test

// file: testbench/gpst_far_model.sv
// Far-side model: test engine, ROM image, program RAM, terminal link.
// Assumes the sequencer's strobes and requests are registered on mclk.
`timescale 1ns/1ps
module gpst_far_model (
	input wire logic mclk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic [15:0] fail_mask, // Engine tests that fail
	input wire logic [2:0] bad_seg, // ROM segment to corrupt
	input wire logic local_mode, // Terminal in local mode
	input wire logic eng_req, // Engine start
	input wire gpst_pkg::gpst_test_t eng_test, // Engine test code
	output gpst_pkg::gpst_eng_rsp_t eng_rsp, // Engine answer
	output logic vec_busy, // Vector drawing
	input wire logic rom_re, // ROM strobe
	input wire logic [14:0] rom_addr, // ROM address
	output logic [7:0] rom_data, // ROM data
	input wire logic ram_re, // RAM read
	input wire logic ram_we, // RAM write
	input wire logic [13:0] ram_addr, // RAM address
	input wire logic [7:0] ram_wdata, // RAM write data
	output logic [7:0] ram_rdata, // RAM read data
	input wire logic link_req, // Status request
	output gpst_pkg::gpst_link_rsp_t link_rsp // Status reply
);
	logic [7:0] mem [16384];
	logic [2:0] cnt;
	logic [1:0] lcnt;
	logic [7:0] seed;
	gpst_pkg::gpst_test_t cur;
	// ==========
	// ROM: zero bytes, last byte closes its checksum; data stands in the strobe cycle
	assign seed = {1'b0, rom_addr[14:12], 4'h1} ^ {7'h00, rom_addr[14:12] == bad_seg};
	assign rom_data = !rom_re ? 8'hA5 :
		(rom_addr[11:0] == 12'hFFF) ? seed : 8'h00;
	// RAM store; read data stands in the strobe cycle, garbled when not read
	always @(posedge mclk) begin
		if (ram_we)
			mem[ram_addr] <= ram_wdata;
	end
	assign ram_rdata = ram_re ? mem[ram_addr] : 8'h5A;
	// Engine answers three cycles after a start; mask bit 15 stalls a vector
	assign vec_busy = (cnt != 3'h0 || fail_mask[15]) &&
		(cur inside {gpst_pkg::T_BM_PART, gpst_pkg::T_VG, gpst_pkg::T_BM_FULL});
	always @(posedge mclk) begin
		eng_rsp <= '0;
		if (!rst_n) begin
			cnt <= 3'h0;
		end else if (eng_req) begin
			cnt <= 3'h3;
			cur <= eng_test;
		end else if (cnt != 3'h0) begin
			cnt <= cnt - 3'h1;
			if (cnt == 3'h1 && !fail_mask[15])
				eng_rsp <= {1'b1, ~fail_mask[cur]};
		end
	end
	// Terminal answers a status request after two cycles
	always @(posedge mclk) begin
		link_rsp <= '0;
		if (!rst_n) begin
			lcnt <= 2'h0;
		end else if (link_req) begin
			lcnt <= 2'h2;
		end else if (lcnt != 2'h0) begin
			lcnt <= lcnt - 2'h1;
			if (lcnt == 2'h1)
				link_rsp <= {1'b1, 1'b1, local_mode};
		end
	end
endmodule : gpst_far_model

// file: testbench/gpst_self_test_tb_top.sv
// Testbench for the self-test sequencer with shortened timing counts.
// Assumes the far-side model answers engine, ROM, RAM and link.
`timescale 1ns/1ps
module gpst_self_test_tb_top;
	logic mclk, rst_n, host_char, cts_start, vsync, vs_on, local_mode;
	logic eng_req, rom_re, ram_re, ram_we, link_req, busy, fatal, vec_busy;
	logic [3:0] cts_sel;
	logic [15:0] fail_mask;
	logic [2:0] bad_seg;
	logic [14:0] rom_addr;
	logic [7:0] rom_data, ram_wdata, ram_rdata;
	logic [13:0] ram_addr;
	logic [1:0] mono_level;
	logic saw_white, saw_red;
	gpst_pkg::gpst_test_t eng_test;
	gpst_pkg::gpst_eng_rsp_t eng_rsp;
	gpst_pkg::gpst_link_rsp_t link_rsp;
	gpst_pkg::gpst_colour_t colour;
	gpst_pkg::gpst_msg_t msg;
	gpst_pkg::gpst_test_t seen_q [$];
	int err_total = 0;
	int comparisons = 0;
	int vs_cnt = 0;
	// ==========
	// Design and far side
	gpst_self_test #(.VSYNC_GAP_CYC(40), .VECTOR_MAX_CYC(20), .FLASH_HALF_CYC(4),
		.LINK_WAIT_CYC(16), .SHOW_STEP_CYC(3)) dut (.mclk, .rst_n, .host_char, .cts_start,
		.cts_sel, .eng_req, .eng_test, .eng_rsp, .rom_re, .rom_addr, .rom_data, .ram_re,
		.ram_we, .ram_addr, .ram_wdata, .ram_rdata, .vsync, .vec_busy, .link_req, .link_rsp,
		.mono_level, .colour, .msg, .busy, .fatal);
	gpst_far_model far (.mclk, .rst_n, .fail_mask, .bad_seg, .local_mode, .eng_req,
		.eng_test, .eng_rsp, .vec_busy, .rom_re, .rom_addr, .rom_data, .ram_re, .ram_we,
		.ram_addr, .ram_wdata, .ram_rdata, .link_req, .link_rsp);
	// ==========
	// Clock, sync pulses every 16 cycles, monitors
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		#1;
		vs_cnt = vs_cnt + 1;
		vsync = vs_on & vs_cnt[3];
	end
	always @(posedge mclk) begin
		if (eng_req === 1'b1)
			seen_q.push_back(eng_test);
		if (colour === 6'h3F)
			saw_white = 1'b1;
		if (colour === 6'h0C)
			saw_red = 1'b1;
	end
	// ==========
	// Shared tasks
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	task automatic step(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : step
	task automatic do_reset();
		rst_n = 1'b0;
		step(2);
		seen_q.delete();
		rst_n = 1'b1;
		step(3);
	endtask : do_reset
	task automatic wait_for(bit want_fatal, int bound);
		for (int i = 0; i < bound; i++) begin
			if (want_fatal ? (fatal === 1'b1) : (busy === 1'b0))
				return;
			step(1);
		end
		check("wait", 8'h00, 8'h01);
		conclude();
	endtask : wait_for
	task automatic request(logic [3:0] s);
		cts_sel = s;
		cts_start = 1'b1;
		step(1);
		cts_start = 1'b0;
		step(2);
		wait_for(1'b0, 2000);
	endtask : request
	task automatic flash(logic [1:0] lo, logic [1:0] hi);
		int n_lo, n_hi, n_req;
		n_lo = 0;
		n_hi = 0;
		n_req = seen_q.size();
		// Skip the edge that latched the error
		step(1);
		repeat (24) begin
			if (mono_level === lo)
				n_lo++;
			else if (mono_level === hi)
				n_hi++;
			step(1);
		end
		check("mono_lo", 8'(n_lo), 8'd12);
		check("mono_hi", 8'(n_hi), 8'd12);
		check("eng_req_after_fatal", 8'(seen_q.size()), 8'(n_req));
		check("fatal_held", {7'h00, fatal}, 8'h01);
	endtask : flash
	// ==========
	// Scenarios
	task automatic t_power_up();
		gpst_pkg::gpst_test_t ex [3] = '{gpst_pkg::T_CPU, gpst_pkg::T_BM_PART, gpst_pkg::T_VG};
		local_mode = 1'b1;
		do_reset();
		wait_for(1'b0, 100000);
		check("pu_count", 8'(seen_q.size()), 8'd3);
		for (int i = 0; i < 3; i++)
			check("pu_order", 8'(seen_q[i]), 8'(ex[i]));
		check("pu_msg", 8'(msg), 8'(gpst_pkg::MSG_OFFLINE));
		check("pu_fatal", {7'h00, fatal}, 8'h00);
		step(50);
		check("no_self_start", 8'(seen_q.size()), 8'd3);
		$display("power-up series done");
	endtask : t_power_up
	task automatic t_requested();
		logic [3:0] sel [4] = '{4'h1, 4'h2, 4'h8, 4'h0};
		gpst_pkg::gpst_test_t tst [4] = '{gpst_pkg::T_HOST, gpst_pkg::T_AUX,
			gpst_pkg::T_BM_FULL, gpst_pkg::T_END};
		gpst_pkg::gpst_msg_t em [4] = '{gpst_pkg::MSG_HOST_LINK_ERROR_CODE,
			gpst_pkg::MSG_SERIAL_PORT_ERROR_CODE, gpst_pkg::MSG_BITMAP_ERROR_CODE,
			gpst_pkg::MSG_OK};
		for (int i = 0; i < 4; i++) begin
			fail_mask = 16'h0001 << tst[i];
			request(sel[i]);
			check("req_msg", 8'(msg), 8'(em[i]));
		end
		host_char = 1'b1;
		step(1);
		host_char = 1'b0;
		step(1);
		check("msg_cleared", 8'(msg), 8'(gpst_pkg::MSG_NONE));
		fail_mask = 16'h0000;
		seen_q.delete();
		saw_white = 1'b0;
		saw_red = 1'b0;
		request(4'hF);
		check("req_count", 8'(seen_q.size()), 8'd3);
		check("req_first", 8'(seen_q[0]), 8'(gpst_pkg::T_HOST));
		check("req_second", 8'(seen_q[1]), 8'(gpst_pkg::T_AUX));
		check("req_third", 8'(seen_q[2]), 8'(gpst_pkg::T_BM_FULL));
		check("white_shown", {7'h00, saw_white}, 8'h01);
		check("red_shown", {7'h00, saw_red}, 8'h01);
		check("req_ok", 8'(msg), 8'(gpst_pkg::MSG_OK));
		$display("requested series done");
	endtask : t_requested
	task automatic t_cpu_fatal();
		fail_mask = 16'h0001 << gpst_pkg::T_CPU;
		do_reset();
		wait_for(1'b1, 300);
		flash(2'h0, 2'h1);
		fail_mask = 16'h0000;
		$display("processor fault done");
	endtask : t_cpu_fatal
	task automatic t_vsync_fatal();
		vs_on = 1'b0;
		do_reset();
		wait_for(1'b1, 400);
		flash(2'h1, 2'h2);
		vs_on = 1'b1;
		$display("sync loss done");
	endtask : t_vsync_fatal
	task automatic t_rom_fatal();
		bad_seg = 3'h1;
		do_reset();
		wait_for(1'b1, 20000);
		flash(2'h0, 2'h2);
		check("rom_colour", 8'(colour), 8'(gpst_pkg::COLOUR_OF[1]));
		bad_seg = 3'h7;
		$display("ROM fault done");
	endtask : t_rom_fatal
	task automatic t_vector_fatal();
		fail_mask = 16'h8000;
		cts_sel = 4'h8;
		cts_start = 1'b1;
		step(1);
		cts_start = 1'b0;
		wait_for(1'b1, 200);
		flash(2'h1, 2'h3);
		fail_mask = 16'h0000;
		$display("vector timeout done");
	endtask : t_vector_fatal
	// ==========
	// Main sequence
	initial begin
		rst_n = 1'b0;
		host_char = 1'b0;
		cts_start = 1'b0;
		cts_sel = 4'h0;
		vsync = 1'b0;
		vs_on = 1'b1;
		local_mode = 1'b0;
		fail_mask = 16'h0000;
		bad_seg = 3'h7;
		saw_white = 1'b0;
		saw_red = 1'b0;
		t_power_up();
		t_requested();
		t_vector_fatal();
		t_cpu_fatal();
		t_vsync_fatal();
		t_rom_fatal();
		conclude();
	end
endmodule : gpst_self_test_tb_top
